// ===== apc_defs.vh
// Purpose: constants for the audio PWM control register bank
// Assumes: byte-wide serial control access at sub-addresses
// Notes: multi-byte words are big-endian, first byte is bits 31:24
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// ----------------------------------------
// Sub-addresses
// ----------------------------------------
`define APC_ADDR_CLOCK 8'h00
`define APC_ADDR_STATUS 8'h01
`define APC_ADDR_SYSCTL1 8'h03
`define APC_ADDR_CH3VOL 8'hd7
`define APC_ADDR_CH4VOL 8'hd8
`define APC_ADDR_MASTERVOL 8'hd9
`define APC_ADDR_BASSSET 8'hda
`define APC_ADDR_BASSLVL 8'hdb
`define APC_ADDR_TREBSET 8'hdc
`define APC_ADDR_TREBLVL 8'hdd
`define APC_ADDR_AMSETUP 8'hde
`define APC_ADDR_SUPRANGE 8'hdf
`define APC_ADDR_GENCTL 8'he0
`define APC_ADDR_APPEND 8'hfe

// ----------------------------------------
// Field positions
// ----------------------------------------
`define APC_CLK_RATE_HI 7
`define APC_CLK_RATE_LO 5
`define APC_CLK_RATIO_HI 4
`define APC_CLK_RATIO_LO 2
`define APC_CLK_VALID_BIT 0
`define APC_RATIO_RESERVED 3'h7
`define APC_SYS_HPF_BIT 7
`define APC_SYS_HARD_BIT 4
`define APC_SYS_HIZ_BIT 3
`define APC_SYS_WRITABLE 8'h98
`define APC_STAT_CLIP_BIT 7
`define APC_STAT_BUSY_BIT 6
`define APC_GEN_TWOCH_BIT 0
`define APC_GEN_SUPVOL_BIT 1
`define APC_APPEND_MIN 3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define APC_RST_CLOCK 8'h6c
`define APC_RST_SYSCTL1 8'h00
`define APC_RST_VOL0DB 32'h00000048
`define APC_RST_MUTE 32'h000000f5
`define APC_RST_SET3 32'h00000003
`define APC_RST_LVL0DB 32'h00000012
`define APC_RST_AMSETUP 32'h00000000
`define APC_RST_SUPRANGE 32'h00000002
`define APC_RST_GENCTL 32'h00000000

`endif

// ===== apc_word_reg.v
// Purpose: one 32-bit word register loaded from an assembled write
// Assumes: load is a single-cycle strobe on clk
// Notes: reset value is a parameter
module apc_word_reg #(
    parameter [31:0] RESET_VALUE = 32'h00000000
) (
    input wire clk,
    input wire sys_rst,
    input wire load,
    input wire [31:0] loadData,
    output reg [31:0] value
);
    // Word storage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            value <= RESET_VALUE;
        end else if (load) begin
            value <= loadData;
        end
    end
endmodule

// ===== apc_clock_check.v
// Purpose: judge whether the programmed clock byte is usable
// Assumes: measured ratio code comes from logic on clk
// Notes: purely combinational
`include "apc_defs.vh"
module apc_clock_check (
    input wire [7:0] clockByte,
    input wire [2:0] measuredRate,
    input wire [2:0] measuredRatio,
    output wire settingsValid
);
    // Valid when ratio is not reserved and the settings match the detected clocks
    assign settingsValid = (clockByte[`APC_CLK_RATIO_HI:`APC_CLK_RATIO_LO] != `APC_RATIO_RESERVED) &&
        (clockByte[`APC_CLK_RATE_HI:`APC_CLK_RATE_LO] == measuredRate) &&
        (clockByte[`APC_CLK_RATIO_HI:`APC_CLK_RATIO_LO] == measuredRatio);
endmodule

// ===== apc_control_regs.v
// Purpose: control and status register bank of the four-channel audio PWM processor
// Assumes: a serial control front end delivers decoded byte strobes on clk
// Notes: multi-byte words commit after their fourth byte; append words go out on appendWord with an appendCoefficient pulse
`include "apc_defs.vh"

// Summary of operation
// - Clock byte bits 7:5 give sample rate, 32 to 192 kHz in order.
// - Clock byte bits 4:2 give MCLK ratio 64 to 768; code 7 reserved.
// - Clock byte bit 1 is ignored on write and reads zero.
// - Clock byte bit 0 is read-only, one when clock settings are valid.
// - Status byte: clip in bit 7, bank-switch busy in bit 6, ID below.
// - System control bits 6, 5, 2, 1, 0 ignored on write.
// - System control bit 7 enables the PWM high-pass filter.
// - System control bit 4 chooses hard or soft unmute after clock error.
// - One bass set and level for all channels; reset set 3, 0 dB.
// - One treble set and level for all channels; reset set 3, 0 dB.
// - AM interference mode resets disabled, sequence 1, 455 kHz, BCD.
// - Supply-volume range word resets to the 12 dB range.
// - General control selects channel mode and supply volume; reset four-channel, off.
module apc_control_regs #(
    parameter [5:0] PART_ID = 6'h2a // Arbitrary identification value
) (
    input wire clk,
    input wire sys_rst,
    input wire frameStart,
    input wire [7:0] subAddress,
    input wire writeStrobe,
    input wire [7:0] writeData,
    input wire frameStop,
    input wire readStrobe,
    output reg [7:0] readData,
    input wire clipDetect,
    input wire bankSwitchBusy,
    input wire [2:0] measuredRate,
    input wire [2:0] measuredRatio,
    input wire clockErrorRecover,
    output wire [2:0] sampleRateCode,
    output wire [2:0] mclkRatioCode,
    output wire clockSettingsValid,
    output wire highPassEnable,
    output wire hardUnmute,
    output wire unmuteRampEnable,
    output wire supplyCompensatedVolumeHizEnable,
    output wire [31:0] channel3Volume,
    output wire [31:0] channel4Volume,
    output wire [31:0] masterVolume,
    output wire [31:0] bassSetSelect,
    output wire [31:0] bassLevelIndex,
    output wire [31:0] trebleSetSelect,
    output wire [31:0] trebleLevelIndex,
    output wire [31:0] amInterferenceSetup,
    output wire [31:0] supplyVolumeRange,
    output wire [31:0] generalControl,
    output wire twoChannelMode,
    output wire supplyCompensatedVolumeEnable,
    output reg appendCoefficient,
    output reg [31:0] appendWord
);
    // ----------------------------------------
    // Local state
    // ----------------------------------------
    localparam WORD_IDLE = 3'h1;
    localparam WORD_FILL = 3'h2;
    localparam WORD_APPEND = 3'h4;

    reg [7:0] clockByte;
    reg [7:0] systemControl;
    reg [2:0] wordState;
    reg [2:0] next_wordState;
    reg [1:0] byteCount;
    reg [23:0] shiftBytes;
    reg [7:0] targetAddress;
    reg [7:0] lastWordAddress;
    reg [2:0] appendBytes;
    reg commitWord;
    reg [7:0] commitAddress;
    reg [31:0] commitData;
    reg [1:0] readIndex;
    reg [7:0] readAddress;
    wire settingsValid;
    wire [31:0] wordValue [0:10];
    wire [31:0] assembled;

    // True for the word-wide sub-addresses in the coefficient map
    function isWordAddr;
        input [7:0] a;
        begin
            isWordAddr = (a >= `APC_ADDR_CH3VOL) && (a <= `APC_ADDR_GENCTL);
        end
    endfunction

    // Index of a word register inside the local table
    function [3:0] wordIndex;
        input [7:0] a;
        reg [7:0] diff;
        begin
            diff = a - `APC_ADDR_CH3VOL;
            wordIndex = diff[3:0];
        end
    endfunction

    // Incoming byte joins below the bytes already collected, so words arrive MSB first
    assign assembled = {shiftBytes, writeData};

    // ----------------------------------------
    // Byte registers
    // ----------------------------------------
    // Clock byte keeps rate and ratio only; bit 1 dropped, bit 0 is computed
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clockByte <= `APC_RST_CLOCK;
        end else if (writeStrobe && wordState == WORD_IDLE && subAddress == `APC_ADDR_CLOCK) begin
            clockByte <= {writeData[`APC_CLK_RATE_HI:`APC_CLK_RATIO_LO], 2'h0};
        end
    end

    // Only bits 7, 4 and 3 of system control hold state
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            systemControl <= `APC_RST_SYSCTL1;
        end else if (writeStrobe && wordState == WORD_IDLE && subAddress == `APC_ADDR_SYSCTL1) begin
            systemControl <= writeData & `APC_SYS_WRITABLE;
        end
    end

    apc_clock_check u_check (
        .clockByte(clockByte),
        .measuredRate(measuredRate),
        .measuredRatio(measuredRatio),
        .settingsValid(settingsValid)
    );

    assign sampleRateCode = clockByte[`APC_CLK_RATE_HI:`APC_CLK_RATE_LO];
    assign mclkRatioCode = clockByte[`APC_CLK_RATIO_HI:`APC_CLK_RATIO_LO];
    assign clockSettingsValid = settingsValid;
    assign highPassEnable = systemControl[`APC_SYS_HPF_BIT];
    assign hardUnmute = systemControl[`APC_SYS_HARD_BIT];
    // Ramp only during a clock-error recovery with soft unmute chosen
    assign unmuteRampEnable = clockErrorRecover & ~systemControl[`APC_SYS_HARD_BIT];
    assign supplyCompensatedVolumeHizEnable = systemControl[`APC_SYS_HIZ_BIT];

    // ----------------------------------------
    // Word assembly state machine
    // ----------------------------------------
    // A word address collects four bytes; the append address collects four-byte words for appendWord
    always @* begin
        next_wordState = wordState;
        case (wordState)
            WORD_IDLE: begin
                if (writeStrobe && isWordAddr(subAddress)) begin
                    next_wordState = WORD_FILL;
                end else if (writeStrobe && subAddress == `APC_ADDR_APPEND) begin
                    next_wordState = WORD_APPEND;
                end
            end
            WORD_FILL: begin
                if (frameStop || frameStart) begin
                    next_wordState = WORD_IDLE;
                end
            end
            WORD_APPEND: begin
                if (frameStop || frameStart) begin
                    next_wordState = WORD_IDLE;
                end
            end
            default: begin
                next_wordState = WORD_IDLE;
            end
        endcase
    end

    // Byte collection and commit strobe; a short word is dropped, never half-written
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wordState <= WORD_IDLE;
            byteCount <= 2'h0;
            shiftBytes <= 24'h000000;
            targetAddress <= 8'h00;
            lastWordAddress <= 8'h00;
            appendBytes <= 3'h0;
            commitWord <= 1'b0;
            commitAddress <= 8'h00;
            commitData <= 32'h00000000;
            appendCoefficient <= 1'b0;
            appendWord <= 32'h00000000;
        end else begin
            wordState <= next_wordState;
            commitWord <= 1'b0;
            appendCoefficient <= 1'b0;
            if (wordState == WORD_IDLE) begin
                byteCount <= 2'h0;
                appendBytes <= 3'h0;
                if (writeStrobe && isWordAddr(subAddress)) begin
                    targetAddress <= subAddress;
                    shiftBytes <= {16'h0000, writeData};
                    byteCount <= 2'h1;
                end else if (writeStrobe && subAddress == `APC_ADDR_APPEND) begin
                    shiftBytes <= {16'h0000, writeData};
                    byteCount <= 2'h1;
                    appendBytes <= 3'h1;
                end
            end else if (writeStrobe) begin
                byteCount <= byteCount + 2'h1;
                if (wordState == WORD_APPEND && appendBytes != `APC_APPEND_MIN) begin
                    appendBytes <= appendBytes + 3'h1;
                end
                if (byteCount == 2'h3) begin
                    // Fourth byte completes a word
                    if (wordState == WORD_FILL) begin
                        commitWord <= 1'b1;
                        commitAddress <= targetAddress;
                        commitData <= assembled;
                        lastWordAddress <= targetAddress;
                        // Subsequent words of the same write stream to the next address
                        targetAddress <= targetAddress + 8'h01;
                    end else begin
                        appendCoefficient <= 1'b1;
                        appendWord <= assembled;
                    end
                end else begin
                    shiftBytes <= assembled[23:0];
                end
            end
        end
    end

    // ----------------------------------------
    // Word registers
    // ----------------------------------------
    apc_word_reg #(.RESET_VALUE(`APC_RST_VOL0DB)) u_ch3 (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_CH3VOL),
        .loadData(commitData), .value(channel3Volume)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_VOL0DB)) u_ch4 (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_CH4VOL),
        .loadData(commitData), .value(channel4Volume)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_MUTE)) u_master (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_MASTERVOL),
        .loadData(commitData), .value(masterVolume)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_SET3)) u_bset (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_BASSSET),
        .loadData(commitData), .value(bassSetSelect)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_LVL0DB)) u_blvl (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_BASSLVL),
        .loadData(commitData), .value(bassLevelIndex)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_SET3)) u_tset (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_TREBSET),
        .loadData(commitData), .value(trebleSetSelect)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_LVL0DB)) u_tlvl (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_TREBLVL),
        .loadData(commitData), .value(trebleLevelIndex)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_AMSETUP)) u_am (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_AMSETUP),
        .loadData(commitData), .value(amInterferenceSetup)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_SUPRANGE)) u_range (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_SUPRANGE),
        .loadData(commitData), .value(supplyVolumeRange)
    );
    apc_word_reg #(.RESET_VALUE(`APC_RST_GENCTL)) u_gen (
        .clk(clk), .sys_rst(sys_rst),
        .load(commitWord && commitAddress == `APC_ADDR_GENCTL),
        .loadData(commitData), .value(generalControl)
    );

    assign twoChannelMode = generalControl[`APC_GEN_TWOCH_BIT];
    assign supplyCompensatedVolumeEnable = generalControl[`APC_GEN_SUPVOL_BIT];

    // Read table in sub-address order; the spare entry keeps the index in range
    assign wordValue[0] = channel3Volume;
    assign wordValue[1] = channel4Volume;
    assign wordValue[2] = masterVolume;
    assign wordValue[3] = bassSetSelect;
    assign wordValue[4] = bassLevelIndex;
    assign wordValue[5] = trebleSetSelect;
    assign wordValue[6] = trebleLevelIndex;
    assign wordValue[7] = amInterferenceSetup;
    assign wordValue[8] = supplyVolumeRange;
    assign wordValue[9] = generalControl;
    assign wordValue[10] = 32'h00000000;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Reads of word registers return bytes MSB first; unmapped addresses read zero
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readData <= 8'h00;
            readIndex <= 2'h0;
            readAddress <= 8'h00;
        end else begin
            if (frameStart) begin
                readIndex <= 2'h0;
                readAddress <= subAddress;
            end else if (readStrobe) begin
                readIndex <= readIndex + 2'h1;
                case (readAddress)
                    `APC_ADDR_CLOCK: begin
                        readData <= {clockByte[7:1], settingsValid};
                    end
                    `APC_ADDR_STATUS: begin
                        readData <= {clipDetect, bankSwitchBusy, PART_ID};
                    end
                    `APC_ADDR_SYSCTL1: begin
                        readData <= systemControl;
                    end
                    default: begin
                        if (isWordAddr(readAddress)) begin
                            case (readIndex)
                                2'h0: readData <= wordValue[wordIndex(readAddress)][31:24];
                                2'h1: readData <= wordValue[wordIndex(readAddress)][23:16];
                                2'h2: readData <= wordValue[wordIndex(readAddress)][15:8];
                                default: readData <= wordValue[wordIndex(readAddress)][7:0];
                            endcase
                        end else begin
                            readData <= 8'h00;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// ===== apc_control_regs_properties.sv
// Purpose: assertions on the ports of the control register bank
// Assumes: one clock domain, reset active high
// Notes: bound to every instance of the bank at the foot of this file
`include "apc_defs.vh"
module apc_control_checker #(
    parameter [5:0] PART_ID = 6'h2a // Arbitrary identification value
) (
    input wire clk,
    input wire sys_rst,
    input wire frameStart,
    input wire [7:0] subAddress,
    input wire writeStrobe,
    input wire [7:0] writeData,
    input wire readStrobe,
    input wire [7:0] readData,
    input wire clipDetect,
    input wire bankSwitchBusy,
    input wire [2:0] measuredRate,
    input wire [2:0] measuredRatio,
    input wire clockErrorRecover,
    input wire [2:0] sampleRateCode,
    input wire [2:0] mclkRatioCode,
    input wire clockSettingsValid,
    input wire highPassEnable,
    input wire hardUnmute,
    input wire unmuteRampEnable,
    input wire supplyCompensatedVolumeHizEnable,
    input wire [31:0] masterVolume,
    input wire [31:0] generalControl,
    input wire twoChannelMode,
    input wire supplyCompensatedVolumeEnable,
    input wire appendCoefficient
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Properties
    // ------------------------------
    // Single domain, so clock and reset are shared by every property
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_clock_write: assert property (
        writeStrobe && $past(frameStart) && subAddress == `APC_ADDR_CLOCK |=>
        {sampleRateCode, mclkRatioCode, 2'b00} == ($past(writeData) & 8'hfc))
        else $error("clock byte write not applied");
    a_valid_flag: assert property (
        clockSettingsValid == (sampleRateCode == measuredRate && mclkRatioCode == measuredRatio
        && mclkRatioCode != `APC_RATIO_RESERVED)) else $error("clock valid flag wrong");
    a_status_read: assert property (
        readStrobe && $past(frameStart) && subAddress == `APC_ADDR_STATUS |=>
        readData == {$past(clipDetect), $past(bankSwitchBusy), PART_ID}) else $error("status byte wrong");
    a_sysctl_write: assert property (
        writeStrobe && $past(frameStart) && subAddress == `APC_ADDR_SYSCTL1 |=>
        {highPassEnable, 2'b00, hardUnmute, supplyCompensatedVolumeHizEnable, 3'h0}
        == ($past(writeData) & `APC_SYS_WRITABLE)) else $error("system control write wrong");
    a_ramp_choice: assert property (
        unmuteRampEnable == (clockErrorRecover && !hardUnmute)) else $error("unmute ramp wrong");
    a_channel_mode: assert property (
        {twoChannelMode, supplyCompensatedVolumeEnable} == {generalControl[0], generalControl[1]})
        else $error("general control decode wrong");
    a_append_pulse: assert property (
        appendCoefficient |=> !appendCoefficient) else $error("append pulse too long");
    a_master_quiet: assert property (
        !$stable(masterVolume) |-> $past(writeStrobe, 2) || $past(writeStrobe, 3) || $past(writeStrobe, 4))
        else $error("master volume changed without a write");
endmodule

bind apc_control_regs apc_control_checker #(.PART_ID(PART_ID)) i_checker (.*);

// ===== apc_host_model.sv
// Purpose: serial control host front end driving the byte strobes
// Assumes: requests launched just after a rising edge
// Notes: gap adds idle cycles between bytes to act as a slow host
module apc_host_model (
    input wire logic clk,
    input wire logic [7:0] readData,
    output logic frameStart,
    output logic [7:0] subAddress,
    output logic writeStrobe,
    output logic [7:0] writeData,
    output logic frameStop,
    output logic readStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    // Idle bus state
    initial begin
        {frameStart, writeStrobe, frameStop, readStrobe} = 4'h0;
        subAddress = 8'h00;
        writeData = 8'h00;
    end
    // Address phase; sub-address then held through the transfer
    task automatic open(input logic [7:0] a);
        @(posedge clk);
        frameStart <= 1'b1;
        subAddress <= a;
        @(posedge clk);
        frameStart <= 1'b0;
    endtask
    // Stop; lines then toggle so stale values are never mistaken for data
    task automatic close();
        writeStrobe <= 1'b0;
        writeData <= ~writeData;
        frameStop <= 1'b1;
        @(posedge clk);
        frameStop <= 1'b0;
        subAddress <= ~subAddress;
    endtask
    // Bytes go most significant first; strobe held high when gap is zero
    task automatic wr(input logic [7:0] a, input int n, input logic [63:0] d);
        open(a);
        for (int i = n - 1; i >= 0; i--) begin
            writeStrobe <= 1'b1;
            writeData <= d[i*8 +: 8];
            @(posedge clk);
            if (gap > 0) begin
                writeStrobe <= 1'b0;
                writeData <= ~d[i*8 +: 8];
                repeat (gap) @(posedge clk);
            end
        end
        close();
    endtask
    // Read byte is taken one cycle after its strobe
    task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d);
        d = 32'h0;
        open(a);
        for (int i = 0; i < n; i++) begin
            readStrobe <= 1'b1;
            @(posedge clk);
            readStrobe <= 1'b0;
            @(posedge clk);
            d = {d[23:0], readData};
        end
        close();
    endtask
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the control register bank
// Assumes: host model drives the byte strobes
// Notes: expected values come from the bank constants
`include "apc_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [5:0] PID = 6'h15; // Arbitrary part code
    logic clk, sys_rst, clipDetect, bankSwitchBusy, clockErrorRecover;
    logic [2:0] measuredRate, measuredRatio;
    wire frameStart, writeStrobe, frameStop, readStrobe, clockSettingsValid, highPassEnable, hardUnmute;
    wire unmuteRampEnable, supplyCompensatedVolumeHizEnable, twoChannelMode, supplyCompensatedVolumeEnable;
    wire appendCoefficient;
    wire [7:0] subAddress, writeData, readData;
    wire [2:0] sampleRateCode, mclkRatioCode;
    wire [31:0] channel3Volume, channel4Volume, masterVolume, bassSetSelect, bassLevelIndex, trebleSetSelect;
    wire [31:0] trebleLevelIndex, amInterferenceSetup, supplyVolumeRange, generalControl, appendWord;
    int error_cnt = 0;
    int cmp_count = 0;
    int appendCnt = 0;
    logic [31:0] d, lastApp;
    logic [31:0] rstTab[10] = '{`APC_RST_VOL0DB, `APC_RST_VOL0DB, `APC_RST_MUTE, `APC_RST_SET3,
        `APC_RST_LVL0DB, `APC_RST_SET3, `APC_RST_LVL0DB, `APC_RST_AMSETUP, `APC_RST_SUPRANGE, `APC_RST_GENCTL};

    apc_control_regs #(.PART_ID(PID)) i_dut (.*);
    apc_host_model i_host (.*);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Append pulses are counted as they happen
    always @(posedge clk) begin
        if (appendCoefficient === 1'b1) begin
            appendCnt <= appendCnt + 1;
            lastApp <= appendWord;
        end
    end

    task automatic done(input string n);
        $display("test %s ends, mismatches so far %0d", n, error_cnt);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: the tests need a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end

    initial begin
        {clipDetect, bankSwitchBusy, clockErrorRecover} = 3'h0;
        measuredRate = 3'h3;
        measuredRatio = 3'h3;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            i_host.rd(`APC_ADDR_CH3VOL + i, 4, d);
            `CHK(d, rstTab[i])
        end
        i_host.rd(`APC_ADDR_CLOCK, 1, d);
        `CHK(d[7:0], `APC_RST_CLOCK | 8'h01)
        // Word outputs seen on the ports, not only through the read path
        `CHK({channel4Volume, bassSetSelect}, {`APC_RST_VOL0DB, `APC_RST_SET3})
        `CHK({amInterferenceSetup, supplyVolumeRange}, {`APC_RST_AMSETUP, `APC_RST_SUPRANGE})
        done("reset");
        // Every rate and ratio code, junk in bit 1 and the read-only bit
        for (int i = 0; i < 8; i++) begin
            measuredRate <= i[2:0];
            measuredRatio <= i[2:0];
            i_host.wr(`APC_ADDR_CLOCK, 1, {i[2:0], i[2:0], 2'b11});
            i_host.rd(`APC_ADDR_CLOCK, 1, d);
            `CHK(d[7:0], {i[2:0], i[2:0], 1'b0, i != 7})
            `CHK({sampleRateCode, mclkRatioCode}, {i[2:0], i[2:0]})
        end
        i_host.wr(`APC_ADDR_CLOCK, 1, 8'h44);
        // Detected clocks must match both programmed codes before the flag may rise
        measuredRate <= 3'h2;
        measuredRatio <= 3'h1;
        @(posedge clk);
        `CHK(clockSettingsValid, 1'b1)
        measuredRatio <= 3'h0;
        @(posedge clk);
        `CHK(clockSettingsValid, 1'b0)
        done("clock");
        i_host.wr(`APC_ADDR_SYSCTL1, 1, 8'hff);
        i_host.rd(`APC_ADDR_SYSCTL1, 1, d);
        `CHK(d[7:0], `APC_SYS_WRITABLE)
        clockErrorRecover <= 1'b1;
        @(posedge clk);
        `CHK({highPassEnable, hardUnmute, supplyCompensatedVolumeHizEnable, unmuteRampEnable}, 4'he)
        i_host.wr(`APC_ADDR_SYSCTL1, 1, 8'h00);
        `CHK({highPassEnable, hardUnmute, supplyCompensatedVolumeHizEnable, unmuteRampEnable}, 4'h1)
        clockErrorRecover <= 1'b0;
        done("sysctl");
        for (int i = 0; i < 4; i++) begin
            {clipDetect, bankSwitchBusy} <= i[1:0];
            i_host.rd(`APC_ADDR_STATUS, 1, d);
            `CHK(d[7:0], {i[1:0], PID})
        end
        i_host.wr(`APC_ADDR_STATUS, 1, 8'h00);
        i_host.rd(`APC_ADDR_STATUS, 1, d);
        `CHK(d[7:0], {2'b11, PID})
        done("status");
        i_host.wr(`APC_ADDR_MASTERVOL, 4, 32'h12345678);
        i_host.rd(`APC_ADDR_MASTERVOL, 4, d);
        `CHK(d, 32'h12345678)
        i_host.gap = 2;
        i_host.wr(`APC_ADDR_BASSLVL, 8, 64'h00000011_00000002);
        i_host.gap = 0;
        i_host.wr(`APC_ADDR_CH3VOL, 3, 24'habcdef);
        i_host.wr(8'he5, 4, 32'h00000003);
        repeat (2) @(posedge clk);
        `CHK({bassLevelIndex, trebleSetSelect, trebleLevelIndex}, {64'h11_00000002, `APC_RST_LVL0DB})
        `CHK({channel3Volume, generalControl}, {`APC_RST_VOL0DB, `APC_RST_GENCTL})
        i_host.wr(`APC_ADDR_GENCTL, 4, 32'h00000003);
        repeat (2) @(posedge clk);
        `CHK({twoChannelMode, supplyCompensatedVolumeEnable}, 2'b11)
        done("words");
        i_host.wr(`APC_ADDR_APPEND, 8, 64'hcafe0001_beef0002);
        i_host.wr(`APC_ADDR_APPEND, 3, 24'h000001);
        repeat (3) @(posedge clk);
        `CHK({appendCnt, lastApp, masterVolume}, {32'd2, 32'hbeef0002, 32'h12345678})
        done("append");
        results();
    end
endmodule
